// ### src/rtcf_pkg.sv
// rtcf_pkg: constants for the rtc interrupt flag and status block.
// assumes a synchronous register port already decoded from the
// multiplexed host bus, on the same clock as the block.
package rtcf_pkg;

    // =========================================================
    // register offsets
    localparam logic [6:0] RTCF_OFS_RATE = 7'h0a;
    localparam logic [6:0] RTCF_OFS_CTRL = 7'h0b;
    localparam logic [6:0] RTCF_OFS_FLAGS = 7'h0c;
    localparam logic [6:0] RTCF_OFS_VALID = 7'h0d;

    // =========================================================
    // field positions
    localparam int RTCF_BIT_INHIBIT = 7;
    localparam int RTCF_BIT_PIE = 6;
    localparam int RTCF_BIT_AIE = 5;
    localparam int RTCF_BIT_UIE = 4;
    localparam int RTCF_BIT_SUMMARY = 7;
    localparam int RTCF_BIT_PF = 6;
    localparam int RTCF_BIT_AF = 5;
    localparam int RTCF_BIT_UF = 4;
    localparam int RTCF_BIT_VALID = 7;

    // =========================================================
    // reset values
    localparam logic [3:0] RTCF_RST_RATE = 4'h0;
    localparam logic [7:0] RTCF_RST_CTRL = 8'h00;
    localparam logic [2:0] RTCF_RST_FLAGS = 3'h0;
    localparam logic [7:0] RTCF_RD_UNMAPPED = 8'h00;

    // alarm byte code that matches any time value
    localparam logic [1:0] RTCF_WILDCARD = 2'h3;

endpackage

// ### src/rtcf_alarm_match.sv
// rtcf_alarm_match: compares three time bytes with three alarm bytes.
// assumes both byte sets are stable in the cycle the result is used.
`timescale 1ns/100ps
module rtcf_alarm_match #(
    parameter int NBYTES = 3
) (
    // byte sets, byte 0 in the low bits
    input wire logic [8*NBYTES-1:0] time_in,
    input wire logic [8*NBYTES-1:0] alarm_in,
    // result
    output logic match_out
);

    // =========================================================
    // per byte compare
    function automatic logic byte_hit(input logic [7:0] t, input logic [7:0] a);
        byte_hit = (a[7:6] == rtcf_pkg::RTCF_WILDCARD) || (a == t);
    endfunction

    logic [NBYTES-1:0] hit;

    genvar i;
    generate
        for (i = 0; i < NBYTES; i++) begin : g_byte
            assign hit[i] = byte_hit(time_in[8*i +: 8], alarm_in[8*i +: 8]);
        end
    endgenerate

    assign match_out = &hit;

endmodule

// ### src/rtcf_irq_flags.sv
// rtcf_irq_flags: interrupt flags, enables, summary request and
// backup validity status of the real-time clock.
// assumes the divider taps, update-end pulse and time/alarm bytes
// come from logic on clk_in; battery_ok_in comes from a pin.
`timescale 1ns/100ps
module rtcf_irq_flags #(
    parameter int NTAPS = 16
) (
    // clock and reset
    input wire logic clk_in,
    input wire logic srst_in,
    // register port
    input wire logic [6:0] reg_addr_in,
    input wire logic reg_rd_in,
    input wire logic reg_wr_in,
    input wire logic [7:0] reg_wdata_in,
    output logic [7:0] reg_rdata_out,
    // time base
    input wire logic [NTAPS-1:0] div_taps_in,
    input wire logic update_done_in,
    input wire logic [23:0] time_bytes_in,
    input wire logic [23:0] alarm_bytes_in,
    // backup supply sense pin
    input wire logic battery_ok_in,
    // open-drain interrupt pin
    output logic irq_out,
    output logic irq_oe_n_out,
    // control seen by the rest of the clock
    output logic [3:0] rate_select_out,
    output logic update_inhibit_out
);

    // =========================================================
    // register state
    logic [3:0] rate_select_q;
    logic [7:0] ctrl_q;
    logic [7:0] ctrl_d;
    logic periodic_flag_q;
    logic periodic_flag_d;
    logic alarm_flag_q;
    logic alarm_flag_d;
    logic update_ended_flag_q;
    logic update_ended_flag_d;
    logic tap_q;
    logic [7:0] rdata_q;
    logic valid_meta_q;
    logic valid_sync_q;

    // =========================================================
    // decode
    // one address compare shared by the strobes and the read mux
    function automatic logic at_ofs(input logic [6:0] addr, input logic [6:0] ofs);
        at_ofs = (addr == ofs);
    endfunction

    wire rd_flags = reg_rd_in && at_ofs(reg_addr_in, rtcf_pkg::RTCF_OFS_FLAGS);
    wire wr_rate = reg_wr_in && at_ofs(reg_addr_in, rtcf_pkg::RTCF_OFS_RATE);
    wire wr_ctrl = reg_wr_in && at_ofs(reg_addr_in, rtcf_pkg::RTCF_OFS_CTRL);

    wire periodic_enable = ctrl_q[rtcf_pkg::RTCF_BIT_PIE];
    wire alarm_enable = ctrl_q[rtcf_pkg::RTCF_BIT_AIE];
    wire update_ended_enable = ctrl_q[rtcf_pkg::RTCF_BIT_UIE];

    // rate 0 selects no tap, so the periodic flag never sets
    // tap_q holds the old tap level, so a rate change may give one early edge
    wire tap_now = (rate_select_q != 4'h0) && div_taps_in[rate_select_q];
    wire tap_edge = tap_now && !tap_q;

    logic alarm_match;

    rtcf_alarm_match #(
        .NBYTES(3)
    ) rtcf_alarm_match_inst (
        .time_in(time_bytes_in),
        .alarm_in(alarm_bytes_in),
        .match_out(alarm_match)
    );

    wire alarm_event = update_done_in && alarm_match;

    // set wins over the read clear so a coincident event shows next read
    assign periodic_flag_d = (periodic_flag_q && !rd_flags) || tap_edge;
    assign alarm_flag_d = (alarm_flag_q && !rd_flags) || alarm_event;
    assign update_ended_flag_d = (update_ended_flag_q && !rd_flags) || update_done_in;

    // combinational, so clearing an enable releases the pin at once
    wire summary_request_flag = (periodic_flag_q && periodic_enable)
        || (alarm_flag_q && alarm_enable)
        || (update_ended_flag_q && update_ended_enable);

    // enables change only through a host write; inhibit clears uie
    wire [7:0] ctrl_wr = reg_wdata_in & ~(reg_wdata_in[rtcf_pkg::RTCF_BIT_INHIBIT]
        ? (8'h01 << rtcf_pkg::RTCF_BIT_UIE) : 8'h00);
    assign ctrl_d = wr_ctrl ? ctrl_wr : ctrl_q;

    // flag register: low nibble is constant zero, writes not decoded
    wire [7:0] flags_view = {summary_request_flag, periodic_flag_q, alarm_flag_q,
        update_ended_flag_q, 4'h0};
    // status register: only the validity bit is live
    wire [7:0] valid_view = {valid_sync_q, 7'h00};

    // unmapped addresses read zero rather than aliasing a register
    wire [7:0] rd_mux =
        at_ofs(reg_addr_in, rtcf_pkg::RTCF_OFS_RATE) ? {4'h0, rate_select_q} :
        at_ofs(reg_addr_in, rtcf_pkg::RTCF_OFS_CTRL) ? ctrl_q :
        at_ofs(reg_addr_in, rtcf_pkg::RTCF_OFS_FLAGS) ? flags_view :
        at_ofs(reg_addr_in, rtcf_pkg::RTCF_OFS_VALID) ? valid_view :
        rtcf_pkg::RTCF_RD_UNMAPPED;

    // =========================================================
    // flops
    // read data moves only on a read strobe, so it stands until the next read
    always_ff @(posedge clk_in) begin
        if (srst_in) begin
            rate_select_q <= rtcf_pkg::RTCF_RST_RATE;
            ctrl_q <= rtcf_pkg::RTCF_RST_CTRL;
            {periodic_flag_q, alarm_flag_q, update_ended_flag_q} <= rtcf_pkg::RTCF_RST_FLAGS;
            tap_q <= 1'b0;
            rdata_q <= rtcf_pkg::RTCF_RD_UNMAPPED;
        end else begin
            rate_select_q <= wr_rate ? reg_wdata_in[3:0] : rate_select_q;
            ctrl_q <= ctrl_d;
            periodic_flag_q <= periodic_flag_d;
            alarm_flag_q <= alarm_flag_d;
            update_ended_flag_q <= update_ended_flag_d;
            tap_q <= tap_now;
            rdata_q <= reg_rd_in ? rd_mux : rdata_q;
        end
    end

    // pin sense crosses in through two flops; reset leaves it invalid
    always_ff @(posedge clk_in) begin
        if (srst_in) begin
            valid_meta_q <= 1'b0;
            valid_sync_q <= 1'b0;
        end else begin
            valid_meta_q <= battery_ok_in;
            valid_sync_q <= valid_meta_q;
        end
    end

    // =========================================================
    // outputs
    assign reg_rdata_out = rdata_q;
    assign irq_out = 1'b0;
    assign irq_oe_n_out = !summary_request_flag;
    assign rate_select_out = rate_select_q;
    assign update_inhibit_out = ctrl_q[rtcf_pkg::RTCF_BIT_INHIBIT];

    // =========================================================
    // assertions
    default clocking cb @(posedge clk_in); endclocking
    default disable iff (srst_in);

    // pin drive
    a_pin_follows_pf: assert property (periodic_flag_q && periodic_enable
        |-> !irq_oe_n_out)
        else $error("pin not driven with periodic flag and enable");
    a_alarm_pin: assert property (alarm_flag_q && alarm_enable |-> !irq_oe_n_out)
        else $error("pin not driven with alarm flag and enable");
    a_update_pin: assert property (update_ended_flag_q && update_ended_enable
        |-> !irq_oe_n_out)
        else $error("pin not driven with update flag and enable");
    a_pin_released: assert property (!periodic_flag_q && !alarm_flag_q
        && !update_ended_flag_q |-> irq_oe_n_out)
        else $error("pin driven with no flag set");
    a_pf_no_pie: assert property (periodic_flag_q && !periodic_enable
        && !alarm_flag_q && !update_ended_flag_q |-> irq_oe_n_out)
        else $error("periodic flag drove pin with enable clear");

    // flag set and clear
    a_read_clears: assert property (rd_flags && !tap_edge && !update_done_in
        |=> !periodic_flag_q && !alarm_flag_q && !update_ended_flag_q && irq_oe_n_out)
        else $error("flag read did not clear flags");
    a_af_holds: assert property (!rd_flags && alarm_flag_q |=> alarm_flag_q)
        else $error("alarm flag dropped without a read");
    a_uf_holds: assert property (!rd_flags && update_ended_flag_q
        |=> update_ended_flag_q)
        else $error("update flag dropped without a read");
    a_tap_sets_pf: assert property (tap_now && !tap_q |=> periodic_flag_q)
        else $error("tap edge did not set periodic flag");
    a_rate_zero: assert property (rate_select_q == 4'h0 |-> !tap_edge)
        else $error("periodic edge seen with rate zero");
    a_alarm_sets_af: assert property (update_done_in && alarm_match |=> alarm_flag_q)
        else $error("alarm match did not set alarm flag");
    a_wildcard_hits: assert property (alarm_bytes_in[23:22] == 2'h3
        && alarm_bytes_in[15:14] == 2'h3 && alarm_bytes_in[7:6] == 2'h3 |-> alarm_match)
        else $error("all-wildcard alarm did not match");
    a_update_sets_uf: assert property (update_done_in |=> update_ended_flag_q)
        else $error("update end did not set its flag");
    a_read_keeps_pf: assert property (rd_flags && tap_edge |=> periodic_flag_q)
        else $error("periodic event lost under a flag read");
    a_read_keeps_af: assert property (rd_flags && alarm_event |=> alarm_flag_q)
        else $error("alarm event lost under a flag read");

    // register views
    a_flags_low_zero: assert property (rd_flags |=> reg_rdata_out[3:0] == 4'h0)
        else $error("flag register low nibble not zero");
    a_flags_read: assert property (rd_flags
        |=> reg_rdata_out[7:4] == {$past(summary_request_flag), $past(periodic_flag_q),
        $past(alarm_flag_q), $past(update_ended_flag_q)})
        else $error("flag register read data wrong");
    a_status_read: assert property (reg_rd_in
        && reg_addr_in == rtcf_pkg::RTCF_OFS_VALID
        |=> reg_rdata_out == {$past(valid_sync_q), 7'h00})
        else $error("status register read wrong");

    // control bits
    a_inhibit_clr_uie: assert property (wr_ctrl
        && reg_wdata_in[rtcf_pkg::RTCF_BIT_INHIBIT] |=> !update_ended_enable)
        else $error("inhibit did not clear update enable");
    a_pie_stable: assert property (!wr_ctrl |=> $stable(periodic_enable))
        else $error("periodic enable changed without a write");
    a_pie_written: assert property (wr_ctrl
        |=> periodic_enable == $past(reg_wdata_in[rtcf_pkg::RTCF_BIT_PIE]))
        else $error("periodic enable did not take the written value");

    // =========================================================
    // cover points
    c_periodic_irq: cover property (periodic_flag_q && periodic_enable ##1 rd_flags);
    c_alarm_irq: cover property (alarm_event && alarm_enable);
    c_clash: cover property (rd_flags && update_done_in);
    c_valid_read: cover property (reg_rd_in && reg_addr_in == rtcf_pkg::RTCF_OFS_VALID);
    c_pin_release: cover property (!irq_oe_n_out ##1 irq_oe_n_out);

endmodule

// ### test/rtcf_tbase_model.sv
// rtcf_tbase_model: free-running divider chain feeding the flag block.
// assumes the block samples its time-base inputs on the rising edge.
`timescale 1ns/100ps
module rtcf_tbase_model (
    // clock
    input wire logic clk_in,
    // divider stage levels
    output logic [15:0] taps_out
);
    // =========================================================
    // divider chain
    // moves on the falling edge so the block never sees a racing tap
    logic [15:0] count_q = 16'h0000;

    always @(negedge clk_in) begin
        count_q <= count_q + 16'h0001;
    end

    assign taps_out = count_q;
endmodule

// ### test/rtcf_irq_flags_tb.sv
// rtcf_irq_flags_tb: register-level tests of the flag and status block.
// assumes one clock domain; inputs change on the falling edge.
`timescale 1ns/100ps
module rtcf_irq_flags_tb;
    logic clk_in = 1'b0;
    logic srst_in = 1'b1;
    logic [6:0] addr = 7'h00;
    logic rd = 1'b0;
    logic wr = 1'b0;
    logic upd = 1'b0;
    logic bat = 1'b1;
    logic [7:0] wdata = 8'h00;
    logic [23:0] alarm = 24'h000000;
    logic [7:0] rdata;
    logic [15:0] taps;
    logic irq, oe_n, inh;
    logic [3:0] rate;
    int num_errors = 0;
    int tests_run = 0;
    int cycles = 0;
    logic [23:0] alm_tab [4] = '{24'h123456, 24'hc03456, 24'h123457, 24'hffc0d9};
    logic [7:0] alm_exp [4] = '{8'hb0, 8'hb0, 8'h10, 8'hb0};

    always #2 clk_in = ~clk_in;

    rtcf_tbase_model rtcf_tbase_model_inst (.clk_in(clk_in), .taps_out(taps));

    rtcf_irq_flags #(.NTAPS(16)) rtcf_irq_flags_inst (
        .clk_in(clk_in), .srst_in(srst_in), .reg_addr_in(addr), .reg_rd_in(rd),
        .reg_wr_in(wr), .reg_wdata_in(wdata), .reg_rdata_out(rdata),
        .div_taps_in(taps), .update_done_in(upd), .time_bytes_in(24'h123456),
        .alarm_bytes_in(alarm), .battery_ok_in(bat), .irq_out(irq),
        .irq_oe_n_out(oe_n), .rate_select_out(rate), .update_inhibit_out(inh));

    // =========================================================
    // tasks
    task automatic chk(input logic [7:0] got, input logic [7:0] exp);
        tests_run++;
        if (got !== exp) begin
            num_errors++;
            $display("ERROR %0t: got %h expected %h", $time, got, exp);
        end
    endtask

    task automatic wreg(input logic [6:0] a, input logic [7:0] d);
        @(negedge clk_in);
        addr = a;
        wdata = d;
        wr = 1'b1;
        @(negedge clk_in);
        wr = 1'b0;
    endtask

    // ev raises an update pulse on the same edge as the read
    task automatic rchk(input logic [6:0] a, input logic [7:0] exp, input logic ev);
        @(negedge clk_in);
        addr = a;
        rd = 1'b1;
        upd = ev;
        @(negedge clk_in);
        rd = 1'b0;
        upd = 1'b0;
        chk(rdata, exp);
    endtask

    task automatic pulse();
        @(negedge clk_in);
        upd = 1'b1;
        @(negedge clk_in);
        upd = 1'b0;
    endtask

    task automatic complete_run();
        if (num_errors == 0 && tests_run > 0) begin
            $display("DONE - PASS");
        end else begin
            $display("DONE - FAIL");
        end
        $finish;
    endtask

    always @(posedge clk_in) begin
        cycles <= cycles + 1;
        if (cycles == 3000) begin
            num_errors++;
            complete_run();
        end
    end

    // =========================================================
    // main sequence
    initial begin
        repeat (4) @(negedge clk_in);
        srst_in = 1'b0;
        repeat (3) @(negedge clk_in);
        chk({7'h00, oe_n}, 8'h01);
        rchk(7'h0d, 8'h80, 1'b0);
        rchk(7'h0b, 8'h00, 1'b0);
        rchk(7'h20, 8'h00, 1'b0);
        wreg(7'h0d, 8'h7f);
        rchk(7'h0d, 8'h80, 1'b0);
        bat = 1'b0;
        repeat (3) @(negedge clk_in);
        rchk(7'h0d, 8'h00, 1'b0);
        bat = 1'b1;
        wreg(7'h0c, 8'hff);
        rchk(7'h0c, 8'h00, 1'b1);
        rchk(7'h0c, 8'h10, 1'b0);
        rchk(7'h0c, 8'h00, 1'b0);
        wreg(7'h0b, 8'h10);
        pulse();
        chk({7'h00, oe_n}, 8'h00);
        rchk(7'h0c, 8'h90, 1'b0);
        chk({7'h00, oe_n}, 8'h01);
        wreg(7'h0b, 8'h20);
        for (int i = 0; i < 4; i++) begin
            alarm = alm_tab[i];
            pulse();
            chk({7'h00, oe_n}, {7'h00, ~alm_exp[i][7]});
            rchk(7'h0c, alm_exp[i], 1'b0);
        end
        for (int p = 0; p < 2; p++) begin
            wreg(7'h0b, (p == 1) ? 8'h40 : 8'h00);
            wreg(7'h0a, 8'hf1);
            rchk(7'h0a, 8'h01, 1'b0);
            chk({4'h0, rate}, 8'h01);
            repeat (4) @(negedge clk_in);
            wreg(7'h0a, 8'h00);
            chk({7'h00, oe_n}, (p == 1) ? 8'h00 : 8'h01);
            rchk(7'h0c, (p == 1) ? 8'hc0 : 8'h40, 1'b0);
        end
        wreg(7'h0b, 8'h9f);
        rchk(7'h0b, 8'h8f, 1'b0);
        chk({7'h00, inh}, 8'h01);
        chk({7'h00, irq}, 8'h00);
        wreg(7'h0b, 8'h10);
        pulse();
        chk({7'h00, oe_n}, 8'h00);
        srst_in = 1'b1;
        repeat (2) @(negedge clk_in);
        srst_in = 1'b0;
        chk({7'h00, oe_n}, 8'h01);
        rchk(7'h0c, 8'h00, 1'b0);
        rchk(7'h0b, 8'h00, 1'b0);
        rchk(7'h0d, 8'h80, 1'b0);
        complete_run();
    end
endmodule
